/* pilc_pkg.sv */
// Package of constants and types for the parallel I/O line controller
package pilc_pkg;

	// ==========================================================
	// Sizes
	localparam int LINE_W = 32;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_OWNER_EN   = 8'h00;
	localparam logic [7:0] OFS_OWNER_DIS  = 8'h04;
	localparam logic [7:0] OFS_OWNER_STS  = 8'h08;
	localparam logic [7:0] OFS_DRV_EN     = 8'h10;
	localparam logic [7:0] OFS_DRV_DIS    = 8'h14;
	localparam logic [7:0] OFS_DRV_STS    = 8'h18;
	localparam logic [7:0] OFS_FILT_EN    = 8'h20;
	localparam logic [7:0] OFS_FILT_DIS   = 8'h24;
	localparam logic [7:0] OFS_FILT_STS   = 8'h28;
	localparam logic [7:0] OFS_LVL_SET    = 8'h30;
	localparam logic [7:0] OFS_LVL_CLR    = 8'h34;
	localparam logic [7:0] OFS_LVL_STS    = 8'h38;
	localparam logic [7:0] OFS_PIN_STS    = 8'h3C;
	localparam logic [7:0] OFS_CHG_STS    = 8'h4C;
	localparam logic [7:0] OFS_SEL_A      = 8'h70;
	localparam logic [7:0] OFS_SEL_B      = 8'h74;
	localparam logic [7:0] OFS_SEL_STS    = 8'h78;
	localparam logic [7:0] OFS_PERMIT_EN  = 8'hA0;
	localparam logic [7:0] OFS_PERMIT_DIS = 8'hA4;
	localparam logic [7:0] OFS_PERMIT_STS = 8'hA8;

	// ==========================================================
	// Reset values
	localparam logic [31:0] RST_ZERO       = 32'h00000000;
	localparam logic [31:0] RST_OWNER_DFLT = 32'hFFFFFFFF;
	localparam logic [31:0] RST_LINE_MASK  = 32'hFFFFFFFF;

	// ==========================================================
	// Peripheral drive of all lines
	typedef struct packed {
		logic [31:0] out;
		logic [31:0] oe;
	} pilc_drive_s;

	// ==========================================================
	// Complete module state
	typedef struct packed {
		logic [31:0] owner;
		logic [31:0] drv;
		logic [31:0] filt;
		logic [31:0] lvl;
		logic [31:0] absel;
		logic [31:0] permit;
		logic [31:0] chg;
		logic [31:0] sync1;
		logic [31:0] sync2;
		logic [31:0] sync3;
		logic [31:0] filt_lvl;
		logic [31:0] prev_lvl;
		logic [31:0] rdata;
	} pilc_state_s;

endpackage

/* pilc_top.sv */
// Parallel I/O line controller: per-line control registers and pad mux
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

module pilc_top #(
	parameter logic [31:0] OWNER_RESET = pilc_pkg::RST_OWNER_DFLT,
	parameter logic [31:0] LINE_MASK   = pilc_pkg::RST_LINE_MASK
) (
	input  wire logic                  mclk_i,
	input  wire logic                  rst_i,
	input  wire logic [7:0]            addr_i,
	input  wire logic [31:0]           wr_data_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic [31:0]                rd_data_o,
	input  wire logic [31:0]           pad_in_i,
	output logic [31:0]                pad_out_o,
	output logic [31:0]                pad_oe_n_o,
	input  wire pilc_pkg::pilc_drive_s periph_a_i,
	input  wire pilc_pkg::pilc_drive_s periph_b_i,
	output logic [31:0]                periph_in_o
);

	// ==========================================================
	// Parameter checks
	if ((OWNER_RESET & ~LINE_MASK) != pilc_pkg::RST_ZERO) begin
		$error("Owner reset value names undefined lines");
	end
	if (LINE_MASK == pilc_pkg::RST_ZERO) begin
		$error("Line mask defines no line");
	end

	// ==========================================================
	// Helpers
	function automatic logic hit(
		input logic       stb,
		input logic [7:0] a,
		input logic [7:0] ofs
	);
		return stb && (a == ofs);
	endfunction

	function automatic logic [31:0] setclr(
		input logic [31:0] cur,
		input logic [31:0] set,
		input logic [31:0] clr
	);
		return (cur | (set & LINE_MASK)) & ~(clr & LINE_MASK);
	endfunction

	function automatic logic [31:0] pick(
		input logic [31:0] sel,
		input logic [31:0] one,
		input logic [31:0] zero
	);
		return (sel & one) | (~sel & zero);
	endfunction

	// ==========================================================
	// State
	pilc_pkg::pilc_state_s q;
	pilc_pkg::pilc_state_s d;

	logic [31:0] stable;
	logic [31:0] cur_lvl;
	logic [31:0] change;
	logic [31:0] set_w;
	logic [31:0] clr_w;
	logic [31:0] sel_out;
	logic [31:0] sel_oe;
	logic [31:0] line_oe;
	logic [31:0] wmask;

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		set_w = pilc_pkg::RST_ZERO;
		clr_w = pilc_pkg::RST_ZERO;

		// Input synchroniser, third stage only feeds the filter
		d.sync1 = pad_in_i;
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;

		// Filter takes a level once it held two samples
		stable = ~(q.sync2 ^ q.sync3);
		d.filt_lvl = pick(stable, q.sync2, q.filt_lvl);

		// Level seen by readback and change detection
		cur_lvl = pick(q.filt, q.filt_lvl, q.sync2) & LINE_MASK;
		d.prev_lvl = cur_lvl;
		change = cur_lvl ^ q.prev_lvl;

		// Line owner
		if (hit(wr_i, addr_i, pilc_pkg::OFS_OWNER_EN)) begin
			d.owner = setclr(q.owner, wr_data_i, pilc_pkg::RST_ZERO);
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_OWNER_DIS)) begin
			d.owner = setclr(q.owner, pilc_pkg::RST_ZERO, wr_data_i);
		end

		// Output driver
		if (hit(wr_i, addr_i, pilc_pkg::OFS_DRV_EN)) begin
			d.drv = setclr(q.drv, wr_data_i, pilc_pkg::RST_ZERO);
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_DRV_DIS)) begin
			d.drv = setclr(q.drv, pilc_pkg::RST_ZERO, wr_data_i);
		end

		// Glitch filter
		if (hit(wr_i, addr_i, pilc_pkg::OFS_FILT_EN)) begin
			d.filt = setclr(q.filt, wr_data_i, pilc_pkg::RST_ZERO);
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_FILT_DIS)) begin
			d.filt = setclr(q.filt, pilc_pkg::RST_ZERO, wr_data_i);
		end

		// Peripheral function select, A clears and B sets
		if (hit(wr_i, addr_i, pilc_pkg::OFS_SEL_A)) begin
			d.absel = setclr(q.absel, pilc_pkg::RST_ZERO, wr_data_i);
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_SEL_B)) begin
			d.absel = setclr(q.absel, wr_data_i, pilc_pkg::RST_ZERO);
		end

		// Direct write permit
		if (hit(wr_i, addr_i, pilc_pkg::OFS_PERMIT_EN)) begin
			d.permit = setclr(q.permit, wr_data_i, pilc_pkg::RST_ZERO);
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_PERMIT_DIS)) begin
			d.permit = setclr(q.permit, pilc_pkg::RST_ZERO, wr_data_i);
		end

		// Queued output level
		if (hit(wr_i, addr_i, pilc_pkg::OFS_LVL_SET)) begin
			set_w = wr_data_i;
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_LVL_CLR)) begin
			clr_w = wr_data_i;
		end else if (hit(wr_i, addr_i, pilc_pkg::OFS_LVL_STS)) begin
			set_w = wr_data_i & q.permit;
			clr_w = ~wr_data_i & q.permit;
		end
		d.lvl = setclr(q.lvl, set_w, clr_w);

		// Change status, new change wins over read clear
		if (hit(rd_i, addr_i, pilc_pkg::OFS_CHG_STS)) begin
			d.chg = change;
		end else begin
			d.chg = q.chg | change;
		end

		// Read data, one cycle after the strobe
		d.rdata = pilc_pkg::RST_ZERO;
		if (hit(rd_i, addr_i, pilc_pkg::OFS_OWNER_STS)) begin
			d.rdata = q.owner;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_DRV_STS)) begin
			d.rdata = q.drv;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_FILT_STS)) begin
			d.rdata = q.filt;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_LVL_STS)) begin
			d.rdata = q.lvl;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_PIN_STS)) begin
			d.rdata = cur_lvl;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_CHG_STS)) begin
			d.rdata = q.chg;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_SEL_STS)) begin
			d.rdata = q.absel;
		end else if (hit(rd_i, addr_i, pilc_pkg::OFS_PERMIT_STS)) begin
			d.rdata = q.permit;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			q          <= '0;
			q.owner    <= OWNER_RESET;
			q.drv      <= pilc_pkg::RST_ZERO;
			q.filt     <= pilc_pkg::RST_ZERO;
			q.lvl      <= pilc_pkg::RST_ZERO;
			q.absel    <= pilc_pkg::RST_ZERO;
			q.permit   <= pilc_pkg::RST_ZERO;
			q.chg      <= pilc_pkg::RST_ZERO;
			q.prev_lvl <= pilc_pkg::RST_ZERO;
			q.rdata    <= pilc_pkg::RST_ZERO;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Pad and peripheral routing, bit n is line n
	always_comb begin
		wmask = LINE_MASK;
		sel_out = pick(q.absel, periph_b_i.out, periph_a_i.out);
		sel_oe = pick(q.absel, periph_b_i.oe, periph_a_i.oe);
		line_oe = pick(q.owner, q.drv, sel_oe) & wmask;
		pad_out_o = pick(q.owner, q.lvl, sel_out) & wmask;
		pad_oe_n_o = ~line_oe;
	end

	// Peripherals see the unfiltered synchronised input
	assign periph_in_o = q.sync2;
	assign rd_data_o = q.rdata;

endmodule

/* pilc_properties.sv */
// Port checker of the line controller
`timescale 1ns/100ps
module pilc_checker (
	input wire logic                  mclk_i,
	input wire logic                  rst_i,
	input wire logic [7:0]            addr_i,
	input wire logic [31:0]           wr_data_i,
	input wire logic                  wr_i,
	input wire logic                  rd_i,
	input wire logic [31:0]           rd_data_o,
	input wire logic [31:0]           pad_in_i,
	input wire logic [31:0]           pad_out_o,
	input wire logic [31:0]           pad_oe_n_o,
	input wire pilc_pkg::pilc_drive_s periph_a_i,
	input wire pilc_pkg::pilc_drive_s periph_b_i,
	input wire logic [31:0]           periph_in_o
);
	default clocking cb_main @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	localparam logic [31:0] ONES = 32'hFFFFFFFF;
	// ====
	// Write of all ones, then owner write two cycles on
	sequence w1(a);
		wr_i && addr_i == a && wr_data_i == ONES;
	endsequence
	sequence then_own(a, b);
		w1(a) ##1 !wr_i ##1 w1(b);
	endsequence
	// ====
	// Properties
	rd_idle_a: assert property (!rd_i |=> rd_data_o == 32'h0)
		else $error("read data not idle");
	wo_read_a: assert property (rd_i && addr_i == 8'h00 |=> rd_data_o == 32'h0)
		else $error("write-only read not zero");
	sel_a_a: assert property (then_own(8'h70, 8'h04) |=> pad_oe_n_o == ~periph_a_i.oe)
		else $error("function A not routed");
	sel_b_a: assert property (then_own(8'h74, 8'h04) |=> pad_out_o == periph_b_i.out)
		else $error("function B not routed");
	lvl_set_a: assert property (then_own(8'h30, 8'h00) |=> pad_out_o == ONES)
		else $error("set level wrong");
	lvl_clr_a: assert property (then_own(8'h34, 8'h00) |=> pad_out_o == 32'h0)
		else $error("clear level wrong");
	drv_off_a: assert property (then_own(8'h14, 8'h00) |=> pad_oe_n_o == ONES)
		else $error("driver not off");
	drv_on_a: assert property (then_own(8'h10, 8'h00) |=> pad_oe_n_o == 32'h0)
		else $error("driver not on");
	sync_in_a: assert property ($stable(pad_in_i)[*4] ##0 (!$past(rst_i) && !$past(rst_i, 2))
		|-> periph_in_o == pad_in_i)
		else $error("peripheral input wrong");
endmodule
bind pilc_top pilc_checker i_pilc_checker (
	.mclk_i      (mclk_i),
	.rst_i       (rst_i),
	.addr_i      (addr_i),
	.wr_data_i   (wr_data_i),
	.wr_i        (wr_i),
	.rd_i        (rd_i),
	.rd_data_o   (rd_data_o),
	.pad_in_i    (pad_in_i),
	.pad_out_o   (pad_out_o),
	.pad_oe_n_o  (pad_oe_n_o),
	.periph_a_i  (periph_a_i),
	.periph_b_i  (periph_b_i),
	.periph_in_o (periph_in_o)
);

/* pilc_bench.sv */
// Self-checking bench of the line controller
`timescale 1ns/100ps
module pilc_bench;
	logic                  mclk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  wr_i = 1'b0;
	logic                  rd_i = 1'b0;
	logic [7:0]            addr_i = 8'h00;
	logic [31:0]           wr_data_i = 32'h0;
	logic [31:0]           pad_in_i = 32'h0;
	logic [31:0]           rd_data_o;
	logic [31:0]           pad_out_o;
	logic [31:0]           pad_oe_n_o;
	logic [31:0]           periph_in_o;
	pilc_pkg::pilc_drive_s periph_a_i = {32'h12345678, 32'h0000FFFF};
	pilc_pkg::pilc_drive_s periph_b_i = {32'h9ABCDEF0, 32'hFFFF0000};
	int                    error_cnt = 0;
	int                    check_count = 0;
	always #12.5 mclk_i = ~mclk_i;
	pilc_top i_pilc_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
		.periph_a_i(periph_a_i), .periph_b_i(periph_b_i), .periph_in_o(periph_in_o));
	// ====
	// Bus and compare
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input bit chk);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1;
		if (!w && chk) cmp(rd_data_o, d);
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, e, 1'b1);
	endtask
	// ====
	// Scenarios
	task automatic t_reset;
		logic [7:0] ofs [8] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h78, 8'hA8, 8'h00, 8'h7C};
		for (int i = 0; i < 8; i++) begin
			rd(ofs[i], (i == 0) ? pilc_pkg::RST_OWNER_DFLT : pilc_pkg::RST_ZERO);
		end
		#1;
		cmp(pad_oe_n_o, 32'hFFFFFFFF);
		@(posedge mclk_i);
	endtask
	task automatic t_owner;
		wr(8'h04, 32'h0000FFFF);
		rd(8'h08, 32'hFFFF0000);
		wr(8'h00, 32'h00000001);
		rd(8'h08, 32'hFFFF0001);
	endtask
	task automatic t_pairs;
		logic [7:0] t [5][3] = '{'{8'h10, 8'h14, 8'h18}, '{8'h20, 8'h24, 8'h28},
			'{8'h30, 8'h34, 8'h38}, '{8'hA0, 8'hA4, 8'hA8}, '{8'h74, 8'h70, 8'h78}};
		for (int i = 0; i < 5; i++) begin
			wr(t[i][0], 32'hF0F0000F);
			wr(t[i][1], 32'h30000001);
			wr(t[i][2], 32'h0000FFFF);
			rd(t[i][2], 32'hC0F0000E);
		end
		wr(8'h38, 32'h0F0F0F0F);
		rd(8'h38, 32'h0000000E);
	endtask
	task automatic t_pad;
		logic [31:0] o = 32'hFFFF0001;
		logic [31:0] s = 32'hC0F0000E;
		logic [7:0]  mux [12] = '{8'h70, 8'h04, 8'h74, 8'h04, 8'h30, 8'h00,
			8'h14, 8'h00, 8'h34, 8'h00, 8'h10, 8'h00};
		#1;
		cmp(pad_oe_n_o, ~(o & s | ~o & (s & periph_b_i.oe | ~s & periph_a_i.oe)));
		cmp(pad_out_o, o & 32'hE | ~o & (s & periph_b_i.out | ~s & periph_a_i.out));
		@(posedge mclk_i);
		foreach (mux[i]) begin
			wr(mux[i], 32'hFFFFFFFF);
		end
		#1;
		cmp(pad_out_o, 32'h00000000);
		cmp(pad_oe_n_o, 32'h00000000);
		@(posedge mclk_i);
	endtask
	task automatic t_pin;
		acc(1'b0, 8'h4C, 32'h0, 1'b0);
		pad_in_i <= 32'h00FF00F0;
		repeat (8) @(posedge mclk_i);
		#1;
		cmp(periph_in_o, 32'h00FF00F0);
		@(posedge mclk_i);
		rd(8'h3C, 32'h00FF00F0);
		rd(8'h4C, 32'h00FF00F0);
		rd(8'h4C, 32'h0);
		pad_in_i <= 32'h00FF00E2;
		@(posedge mclk_i);
		pad_in_i <= 32'h00FF00F0;
		repeat (8) @(posedge mclk_i);
		rd(8'h4C, 32'h00000010);
	endtask
	task automatic t_rerst;
		rst_i <= 1'b1;
		@(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset;
		rd(8'h3C, 32'h00FF00F0);
		rd(8'h4C, 32'h00FF00F0);
	endtask
	// ====
	// Run control
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset;
		t_owner;
		t_pairs;
		t_pad;
		t_pin;
		t_rerst;
		finish_test;
	end
	initial begin
		#20000;
		error_cnt++;
		finish_test;
	end
endmodule
